/* File: design/wtu_pkg.sv */
package wtu_pkg;

    // Special function register map
    localparam logic [7:0] WTU_RESTART_KEY_ADDR = 8'ha6;
    localparam logic [7:0] WTU_TIMEOUT_PROGRAM_ADDR = 8'ha7;

    // Restart key bytes, first then second
    localparam logic [7:0] WTU_KEY_FIRST = 8'h1e;
    localparam logic [7:0] WTU_KEY_SECOND = 8'he1;

    // Time-out program register layout
    localparam int WTU_TIMEOUT_SEL_LSB = 0;
    localparam int WTU_TIMEOUT_SEL_WIDTH = 3;
    localparam logic [2:0] WTU_TIMEOUT_SEL_RESET = 3'h0;
    localparam logic [7:0] WTU_READ_ZERO = 8'h00;

    // Counter structure
    localparam int WTU_PRESCALER_WIDTH = 14;
    localparam int WTU_COUNTER_WIDTH = 7;
    localparam int WTU_COUNT_WIDTH = WTU_PRESCALER_WIDTH + WTU_COUNTER_WIDTH;
    localparam logic [20:0] WTU_COUNT_RESET = 21'h000000;

    // Watchdog clocks per count tick
    localparam int WTU_CLOCKS_PER_TICK = 6;
    localparam logic [2:0] WTU_TICK_LAST = 3'h5;

    // Clock rates
    localparam longint WTU_CLK_SYS_HZ = 64'd20000000;
    localparam longint WTU_OSC_HZ = 64'd20000000;

    // Reset pulse length in oscillator periods, and in clk_sys cycles
    localparam longint WTU_RESET_PULSE_OSC_PERIODS = 64'd96;
    localparam longint WTU_RESET_PULSE_CYCLES_RAW =
        (WTU_RESET_PULSE_OSC_PERIODS * WTU_CLK_SYS_HZ + WTU_OSC_HZ - 64'd1) / WTU_OSC_HZ;
    localparam logic [6:0] WTU_RESET_PULSE_LAST = 7'(WTU_RESET_PULSE_CYCLES_RAW - 64'd1);
    localparam logic [6:0] WTU_PULSE_COUNT_RESET = 7'h00;

    typedef enum logic [1:0] {
        RUN_DISARMED,
        RUN_ARMED,
        RUN_FIRING
    } wtu_run_state_type;

    typedef enum logic {
        KEY_IDLE,
        KEY_HALF
    } wtu_key_state_type;

endpackage

/* File: design/wtu_tick_gen.sv */
module wtu_tick_gen
    import wtu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic halfRate,
    input wire logic run,
    output logic tick
);

    typedef struct packed {
        logic halfPhase;
        logic [2:0] phaseCount;
        logic tick;
    } wtu_tick_state_type;

    wtu_tick_state_type st_q;
    wtu_tick_state_type st_d;
    logic wdtClockEn;

    always_comb begin
        st_d = st_q;
        // A tick pending at power-down entry is kept until wake-up
        if (run) begin
            st_d.tick = 1'b0;
        end
        // Half rate takes every other oscillator cycle
        wdtClockEn = run && (!halfRate || st_q.halfPhase);
        if (run) begin
            st_d.halfPhase = !st_q.halfPhase;
        end
        if (wdtClockEn) begin
            if (st_q.phaseCount == WTU_TICK_LAST) begin
                st_d.phaseCount = 3'h0;
                st_d.tick = 1'b1;
            end else begin
                st_d.phaseCount = st_q.phaseCount + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;

endmodule

/* File: design/wtu_top.sv */
// Notes on behaviour
// - 14-bit prescaler then 7-bit counter, overflow ends.
// - Chip reset clears count, leaves watchdog disabled.
// - Key 1Eh then E1h clears and enables.
// - Enabled watchdog cannot be disabled by software.
// - Overflow drives reset output high 96 periods.
// - Clock select set: watchdog clock is osc/2.
// - Select clear: osc/2 standard, osc double-speed.
// - Time-out is 6*2^(14+field) watchdog clocks.
// - Counting continues during idle mode.
// - Power-down freezes the count.
// - Interrupt wake-up resumes from held count.
// - Reset ending power-down clears and disables.
// - Restart register write-only at A6h.
// - Program bits 7:3 reserved, field bits 2:0.
// - Field resets to zero, shortest time-out.
module wtu_top
    import wtu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrWrData,
    output logic [7:0] sfrRdData,
    output logic sfrRdValid,
    input wire logic watchdogClockSelect,
    input wire logic doubleSpeedMode,
    input wire logic idleMode,
    input wire logic powerDown,
    output logic chipResetOut,
    output logic watchdogEnabled,
    output logic [6:0] watchdogCounter
);

    typedef struct packed {
        wtu_run_state_type runState;
        wtu_key_state_type keyState;
        logic [20:0] count;
        logic [2:0] timeoutSel;
        logic [6:0] pulseCount;
        logic [7:0] rdData;
        logic rdValid;
        logic chipReset;
        logic enabled;
    } wtu_state_type;

    wtu_state_type st_q;
    wtu_state_type st_d;

    logic tick;
    logic tickLive;
    logic halfRate;
    logic tickRun;
    logic keyWrite;
    logic progWrite;
    logic progRead;
    logic serviceNow;
    logic overflowNow;
    logic [20:0] limit;

    // Last count value before overflow for a given field
    function automatic logic [20:0] timeoutLimit(input logic [2:0] sel);
        logic [21:0] full;
        full = 22'h000001 << (WTU_PRESCALER_WIDTH + int'(sel));
        return 21'(full - 22'h000001);
    endfunction

    function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    // Double-speed only applies while the select bit is clear
    assign halfRate = watchdogClockSelect || !doubleSpeedMode;

    // Idle does not gate the tick; power-down stops the phase clocks
    assign tickRun = !powerDown;

    wtu_tick_gen tickGen (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .halfRate(halfRate),
        .run(tickRun),
        .tick(tick)
    );

    // A tick already in flight must not land in the first power-down cycle
    assign tickLive = tick && tickRun;

    assign keyWrite = sfrWrite && addrHit(sfrAddr, WTU_RESTART_KEY_ADDR);
    assign progWrite = sfrWrite && addrHit(sfrAddr, WTU_TIMEOUT_PROGRAM_ADDR);
    assign progRead = sfrRead && addrHit(sfrAddr, WTU_TIMEOUT_PROGRAM_ADDR);

    // Second key byte as the next restart register write after the first
    assign serviceNow = keyWrite && (st_q.keyState == KEY_HALF) && (sfrWrData == WTU_KEY_SECOND);

    assign limit = timeoutLimit(st_q.timeoutSel);
    assign overflowNow = (st_q.runState == RUN_ARMED) && tickLive && (st_q.count == limit) && !serviceNow;

    always_comb begin
        st_d = st_q;
        st_d.rdValid = 1'b0;

        // Key sequence detector; writes elsewhere leave it alone
        if (keyWrite) begin
            if (sfrWrData == WTU_KEY_FIRST) begin
                st_d.keyState = KEY_HALF;
            end else begin
                st_d.keyState = KEY_IDLE;
            end
        end

        // Reserved upper bits are not stored
        if (progWrite) begin
            st_d.timeoutSel = sfrWrData[WTU_TIMEOUT_SEL_LSB +: WTU_TIMEOUT_SEL_WIDTH];
        end

        // Restart register reads as zero; reserved bits read as zero
        if (sfrRead) begin
            st_d.rdValid = 1'b1;
            if (progRead) begin
                st_d.rdData = {5'h00, st_q.timeoutSel};
            end else begin
                st_d.rdData = WTU_READ_ZERO;
            end
        end

        unique case (st_q.runState)
            RUN_DISARMED: begin
                if (serviceNow) begin
                    st_d.count = WTU_COUNT_RESET;
                    st_d.runState = RUN_ARMED;
                    st_d.keyState = KEY_IDLE;
                end
            end
            RUN_ARMED: begin
                // No path back to disarmed except through reset
                if (serviceNow) begin
                    st_d.count = WTU_COUNT_RESET;
                    st_d.keyState = KEY_IDLE;
                end else if (overflowNow) begin
                    st_d.runState = RUN_FIRING;
                    st_d.pulseCount = WTU_PULSE_COUNT_RESET;
                    st_d.chipReset = 1'b1;
                    st_d.count = WTU_COUNT_RESET;
                end else if (tickLive) begin
                    st_d.count = st_q.count + 21'h000001;
                end
            end
            RUN_FIRING: begin
                // The pulse itself is a chip reset: it clears and disarms
                st_d.count = WTU_COUNT_RESET;
                st_d.keyState = KEY_IDLE;
                st_d.timeoutSel = WTU_TIMEOUT_SEL_RESET;
                if (st_q.pulseCount == WTU_RESET_PULSE_LAST) begin
                    st_d.chipReset = 1'b0;
                    st_d.runState = RUN_DISARMED;
                end else begin
                    st_d.pulseCount = st_q.pulseCount + 7'h01;
                end
            end
        endcase

        st_d.enabled = (st_d.runState == RUN_ARMED);
    end

    // Reset also ends power-down, so the same path clears and disarms
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_q.runState <= RUN_DISARMED;
            st_q.keyState <= KEY_IDLE;
            st_q.count <= WTU_COUNT_RESET;
            st_q.timeoutSel <= WTU_TIMEOUT_SEL_RESET;
            st_q.pulseCount <= WTU_PULSE_COUNT_RESET;
            st_q.rdData <= WTU_READ_ZERO;
            st_q.rdValid <= 1'b0;
            st_q.chipReset <= 1'b0;
            st_q.enabled <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sfrRdData = st_q.rdData;
    assign sfrRdValid = st_q.rdValid;
    assign chipResetOut = st_q.chipReset;
    assign watchdogEnabled = st_q.enabled;
    assign watchdogCounter = st_q.count[20:14];

endmodule

/* File: tb/wtu_top_chk.sv */
module wtu_top_chk
    import wtu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrWrData,
    input wire logic [7:0] sfrRdData,
    input wire logic sfrRdValid,
    input wire logic powerDown,
    input wire logic chipResetOut,
    input wire logic watchdogEnabled,
    input wire logic [6:0] watchdogCounter
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] pulseCnt_q;
    // Counts high cycles so the fall edge sees the full pulse length
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !chipResetOut) begin
            pulseCnt_q <= 8'h00;
        end else begin
            pulseCnt_q <= pulseCnt_q + 8'h01;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_read_answer: assert property (sfrRead |=> sfrRdValid) else $error("read not answered");
    chk_read_zero: assert property (sfrRdValid && $past(sfrAddr) != WTU_TIMEOUT_PROGRAM_ADDR
        |-> sfrRdData == WTU_READ_ZERO) else $error("write-only or unmapped read not zero");
    chk_reserved_zero: assert property (sfrRdValid |-> sfrRdData[7:3] == 5'h00)
        else $error("reserved bits not zero");
    chk_key_arms: assert property (sfrWrite && sfrAddr == WTU_RESTART_KEY_ADDR
        && sfrWrData == WTU_KEY_SECOND && $past(sfrWrite && sfrAddr == WTU_RESTART_KEY_ADDR
        && sfrWrData == WTU_KEY_FIRST) && !chipResetOut && !$past(chipResetOut) |=> watchdogEnabled)
        else $error("key pair did not arm");
    chk_no_disarm: assert property (watchdogEnabled |=> watchdogEnabled || chipResetOut)
        else $error("armed watchdog dropped");
    chk_fire_armed: assert property ($rose(chipResetOut) |-> $past(watchdogEnabled))
        else $error("reset pulse while disarmed");
    chk_pulse_len: assert property ($fell(chipResetOut) |-> pulseCnt_q == 8'h60)
        else $error("reset pulse length wrong");
    chk_pulse_max: assert property (chipResetOut |-> pulseCnt_q < 8'h60) else $error("reset pulse too long");
    chk_pulse_clear: assert property (chipResetOut |-> !watchdogEnabled && watchdogCounter == 7'h00)
        else $error("state not cleared during pulse");
    chk_freeze_pd: assert property (powerDown && $past(powerDown)
        |-> $stable(watchdogCounter) && !$rose(chipResetOut)) else $error("counting in power-down");
    chk_disarmed_zero: assert property (!watchdogEnabled |-> watchdogCounter == 7'h00)
        else $error("disarmed count not zero");
endmodule
bind wtu_top wtu_top_chk u_chk(.clk_sys(clk_sys), .reset_n(reset_n), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
    .sfrRdValid(sfrRdValid), .powerDown(powerDown), .chipResetOut(chipResetOut),
    .watchdogEnabled(watchdogEnabled), .watchdogCounter(watchdogCounter));

/* File: tb/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import wtu_pkg::*;
    logic clk_sys = 1'b0, reset_n = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0, sfrRdValid;
    logic idleMode = 1'b0, powerDown = 1'b0, chipResetOut, watchdogEnabled;
    logic wdClkSel = 1'b0, dblSpeed = 1'b1;
    logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData;
    logic [6:0] watchdogCounter;
    int bad_count = 0, total_checks = 0, n = 0, t0 = 0;
    always #25 clk_sys = ~clk_sys;
    // Fast watchdog clock keeps the shortest overflow inside the run budget
    wtu_top u_wtu_top(.clk_sys(clk_sys), .reset_n(reset_n), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
        .sfrRead(sfrRead), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .sfrRdValid(sfrRdValid),
        .watchdogClockSelect(wdClkSel), .doubleSpeedMode(dblSpeed), .idleMode(idleMode), .powerDown(powerDown),
        .chipResetOut(chipResetOut), .watchdogEnabled(watchdogEnabled), .watchdogCounter(watchdogCounter));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        sfrWrite = 1'b1;
        sfrAddr = a;
        sfrWrData = d;
        @(negedge clk_sys);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        sfrWrite = 1'b0;
        sfrRead = 1'b1;
        sfrAddr = a;
        @(negedge clk_sys);
        sfrRead = 1'b0;
        chk({7'h00, sfrRdValid}, 8'h01);
        chk(sfrRdData, exp);
        @(negedge clk_sys);
    endtask
    task key;
        wr(WTU_RESTART_KEY_ADDR, WTU_KEY_FIRST);
        wr(WTU_RESTART_KEY_ADDR, WTU_KEY_SECOND);
        sfrWrite = 1'b0;
        @(negedge clk_sys);
    endtask
    task hold(input int c);
        repeat (c) @(negedge clk_sys);
    endtask
    initial begin
        hold(16);
        reset_n = 1'b1;
        chk({6'h00, watchdogEnabled, chipResetOut}, 8'h00);
        rd(WTU_TIMEOUT_PROGRAM_ADDR, 8'h00);
        rd(WTU_RESTART_KEY_ADDR, 8'h00);
        rd(8'h10, 8'h00);
        wr(WTU_TIMEOUT_PROGRAM_ADDR, 8'h07);
        rd(WTU_TIMEOUT_PROGRAM_ADDR, 8'h07);
        wr(WTU_TIMEOUT_PROGRAM_ADDR, 8'h00);
        wr(WTU_RESTART_KEY_ADDR, WTU_KEY_FIRST);
        wr(WTU_RESTART_KEY_ADDR, 8'h55);
        wr(WTU_RESTART_KEY_ADDR, WTU_KEY_SECOND);
        sfrWrite = 1'b0;
        hold(2);
        chk({7'h00, watchdogEnabled}, 8'h00);
        wr(WTU_RESTART_KEY_ADDR, WTU_KEY_FIRST);
        wr(WTU_TIMEOUT_PROGRAM_ADDR, 8'h00);
        wr(WTU_RESTART_KEY_ADDR, WTU_KEY_SECOND);
        wr(WTU_RESTART_KEY_ADDR, 8'h00);
        sfrWrite = 1'b0;
        hold(2);
        chk({7'h00, watchdogEnabled}, 8'h01);
        $display("registers and key done");
        idleMode = 1'b1;
        hold(100);
        key;
        t0 = n;
        hold(2000);
        powerDown = 1'b1;
        hold(500);
        powerDown = 1'b0;
        while (chipResetOut !== 1'b1 && n - t0 < 99000) @(negedge clk_sys);
        // Tick phase is free running, so allow 11 cycles (under two ticks) of slack either way
        chk({7'h00, n - t0 >= 98790 && n - t0 <= 98812}, 8'h01);
        t0 = n;
        while (chipResetOut === 1'b1 && n - t0 < 200) @(negedge clk_sys);
        chk(8'(n - t0), 8'h60);
        chk({7'h00, watchdogEnabled}, 8'h00);
        rd(WTU_TIMEOUT_PROGRAM_ADDR, 8'h00);
        $display("overflow done");
        key;
        chk({7'h00, watchdogEnabled}, 8'h01);
        powerDown = 1'b1;
        reset_n = 1'b0;
        hold(2);
        reset_n = 1'b1;
        powerDown = 1'b0;
        hold(1);
        chk({1'b0, watchdogCounter}, 8'h00);
        chk({7'h00, watchdogEnabled}, 8'h00);
        $display("power-down reset done");
        close_out;
    end
    always @(posedge clk_sys) n <= n + 1;
    initial begin
        #5500000;
        bad_count++;
        close_out;
    end
endmodule
